// file: logic/adst_sequencer.v
// Design decisions made here: register access over APB and the register offsets.
`include "adst_consts.vh"

// How it works
// - each sequence has its own trigger select
// - trigger codes map to listed event sources
// - start write converts while sequence enabled
// - polarity, enable, start in one write
// - result is unsigned 12 bits, stored as converted
// - twelve inputs muxed by channel index
// - channel bitmask, bit n is channel n
// - single step: one channel per trigger
// - otherwise one trigger converts all selected channels
// - sequence mode interrupts after last channel
// - each channel result in own register
// - sample at start, minimum 6.5 clocks
// - default conversion takes 31 converter clocks
// - per-sequence extra sample clocks
// - divide zero passes clock undivided
// - low power: off idle, wake on trigger
// - four separate interrupt outputs
// - enabled sequence loads its channels on a trigger only when no channels are pending
// - sync divider or independent async tick

module adst_sequencer (
    // clock and reset
    input wire clock,
    input wire reset,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // hardware trigger sources
    input wire pin_event_zero,
    input wire pin_event_one,
    input wire timer_match_three,
    input wire comparator_output_trigger,
    input wire pattern_match_event,
    input wire core_transmit_event,
    // asynchronous converter clock tick
    input wire async_conv_tick,
    // converter core
    output reg [3:0] conv_channel,
    output reg conv_sample,
    output reg conv_power,
    input wire [11:0] conv_code,
    // interrupts
    output reg first_sequence_interrupt,
    output reg second_sequence_interrupt,
    output reg threshold_interrupt,
    output reg overrun_interrupt
);
    localparam ST_IDLE = 2'd0;
    localparam ST_WAKE = 2'd1;
    localparam ST_CONV = 2'd2;

    reg [31:0] control;
    reg [31:0] first_sequence_config;
    reg [31:0] second_sequence_config;
    reg [11:0] channel_result_reg [0:11];
    reg [11:0] done_mask;
    reg [15:0] gdat_a;
    reg [15:0] gdat_b;
    reg [11:0] pend_a;
    reg [11:0] pend_b;
    reg [1:0] state;
    reg cur_b;
    reg [5:0] clk_count;
    reg [5:0] conv_len;
    reg [8:0] trig_a_q;
    reg wait_a;
    reg wait_b;
    reg [2:0] sync0;
    reg [2:0] sync1;
    reg [2:0] sync2;
    reg [2:0] sync3;
    reg [2:0] sync4;
    reg [2:0] sync5;
    reg ev_prev_a;
    reg ev_prev_b;
    reg overrun;
    integer i;

    wire conv_tick;
    wire [8:0] trig_vec;
    wire wr;
    wire rd;
    wire start_a;
    wire start_b;
    wire hw_a;
    wire hw_b;
    wire ev_a;
    wire ev_b;
    wire go_a = (pend_a != 12'h000) & ~wait_a;
    wire go_b = (pend_b != 12'h000) & ~wait_b;

    adst_clock_divider u_div (
        .clock(clock),
        .reset(reset),
        .divide(control[`ADST_CTRL_DIV_MSB:`ADST_CTRL_DIV_LSB]),
        .async_mode(control[`ADST_CTRL_ASYNC_BIT]),
        .async_tick(async_conv_tick),
        .conv_tick(conv_tick)
    );

    // select hardware trigger level by code
    function sel_trig;
        input [3:0] code;
        input [8:0] vec;
        begin
            case (code)
                `ADST_TRIG_PIN0: sel_trig = vec[1];
                `ADST_TRIG_PIN1: sel_trig = vec[2];
                `ADST_TRIG_TMR3: sel_trig = vec[5];
                `ADST_TRIG_CMP: sel_trig = vec[6];
                `ADST_TRIG_PMATCH: sel_trig = vec[7];
                `ADST_TRIG_TXEV: sel_trig = vec[8];
                default: sel_trig = 1'b0;
            endcase
        end
    endfunction

    // lowest set bit of a mask as one-hot
    function [11:0] lowest;
        input [11:0] m;
        begin
            lowest = m & (~m + 12'h001);
        end
    endfunction

    // index of a one-hot bit
    function [3:0] index_of;
        input [11:0] oh;
        integer k;
        begin
            index_of = 4'h0;
            for (k = 0; k < 12; k = k + 1)
                if (oh[k])
                    index_of = k[3:0];
        end
    endfunction

    // all six trigger inputs pass three flops, change taken when last two agree
    always @(posedge clock) begin
        if (reset) begin
            sync0 <= 3'h0;
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
            sync4 <= 3'h0;
            sync5 <= 3'h0;
        end else begin
            sync0 <= {sync0[1:0], pin_event_zero};
            sync1 <= {sync1[1:0], pin_event_one};
            sync2 <= {sync2[1:0], timer_match_three};
            sync3 <= {sync3[1:0], comparator_output_trigger};
            sync4 <= {sync4[1:0], pattern_match_event};
            sync5 <= {sync5[1:0], core_transmit_event};
        end
    end

    always @(posedge clock) begin
        if (reset) begin
            trig_a_q <= 9'h000;
        end else begin
            if (sync0[2] == sync0[1]) trig_a_q[1] <= sync0[2];
            if (sync1[2] == sync1[1]) trig_a_q[2] <= sync1[2];
            if (sync2[2] == sync2[1]) trig_a_q[5] <= sync2[2];
            if (sync3[2] == sync3[1]) trig_a_q[6] <= sync3[2];
            if (sync4[2] == sync4[1]) trig_a_q[7] <= sync4[2];
            if (sync5[2] == sync5[1]) trig_a_q[8] <= sync5[2];
        end
    end
    assign trig_vec = trig_a_q;

    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;

    // edge of selected trigger, polarity applied
    assign hw_a = sel_trig(first_sequence_config[`ADST_SEQ_TRIG_MSB:
        `ADST_SEQ_TRIG_LSB], trig_vec)
        ^ ~first_sequence_config[`ADST_SEQ_POL_BIT];
    assign hw_b = sel_trig(second_sequence_config[`ADST_SEQ_TRIG_MSB:
        `ADST_SEQ_TRIG_LSB], trig_vec)
        ^ ~second_sequence_config[`ADST_SEQ_POL_BIT];
    assign ev_a = hw_a & ~ev_prev_a & sel_trig(first_sequence_config[
        `ADST_SEQ_TRIG_MSB:`ADST_SEQ_TRIG_LSB], 9'h1ff);
    assign ev_b = hw_b & ~ev_prev_b & sel_trig(second_sequence_config[
        `ADST_SEQ_TRIG_MSB:`ADST_SEQ_TRIG_LSB], 9'h1ff);

    // start write uses the enable in the same written word
    assign start_a = wr & (paddr == `ADST_SEQA_OFF)
        & pwdata[`ADST_SEQ_START_BIT] & pwdata[`ADST_SEQUENCE_ENABLE_BIT_BIT];
    assign start_b = wr & (paddr == `ADST_SEQB_OFF)
        & pwdata[`ADST_SEQ_START_BIT] & pwdata[`ADST_SEQUENCE_ENABLE_BIT_BIT];

    // register writes and trigger capture
    always @(posedge clock) begin
        if (reset) begin
            control <= `ADST_CTRL_RST;
            first_sequence_config <= `ADST_SEQ_RST;
            second_sequence_config <= `ADST_SEQ_RST;
            ev_prev_a <= 1'b0;
            ev_prev_b <= 1'b0;
        end else begin
            ev_prev_a <= hw_a;
            ev_prev_b <= hw_b;
            if (wr && paddr == `ADST_CTRL_OFF)
                control <= pwdata;
            if (wr && paddr == `ADST_SEQA_OFF)
                first_sequence_config <= pwdata & ~32'h0400_0000;
            if (wr && paddr == `ADST_SEQB_OFF)
                second_sequence_config <= pwdata & ~32'h0400_0000;
        end
    end

    // conversion engine
    always @(posedge clock) begin
        if (reset) begin
            state <= ST_IDLE;
            pend_a <= 12'h000;
            pend_b <= 12'h000;
            cur_b <= 1'b0;
            wait_a <= 1'b0;
            wait_b <= 1'b0;
            clk_count <= 6'd0;
            conv_len <= `ADST_CONV_CLKS;
            conv_channel <= 4'h0;
            conv_sample <= 1'b0;
            conv_power <= 1'b0;
            done_mask <= 12'h000;
            gdat_a <= 16'h0000;
            gdat_b <= 16'h0000;
            overrun <= 1'b0;
            first_sequence_interrupt <= 1'b0;
            second_sequence_interrupt <= 1'b0;
            threshold_interrupt <= 1'b0;
            overrun_interrupt <= 1'b0;
            for (i = 0; i < 12; i = i + 1)
                channel_result_reg[i] <= 12'h000;
        end else begin
            first_sequence_interrupt <= 1'b0;
            second_sequence_interrupt <= 1'b0;
            overrun_interrupt <= overrun;
            conv_sample <= 1'b0;
            // a trigger arms the selected channels of its sequence
            if (rd && paddr == `ADST_STAT_OFF)
                overrun <= 1'b0;
            if (first_sequence_config[`ADST_SEQUENCE_ENABLE_BIT_BIT] == 1'b0)
                pend_a <= 12'h000;
            else if (ev_a && pend_a == 12'h000)
                pend_a <= first_sequence_config[`ADST_SEQ_CH_MSB:0];
            if (start_a && pend_a == 12'h000)
                pend_a <= pwdata[`ADST_SEQ_CH_MSB:0];
            if (ev_a || start_a) wait_a <= 1'b0;
            if (second_sequence_config[`ADST_SEQUENCE_ENABLE_BIT_BIT] == 1'b0)
                pend_b <= 12'h000;
            else if (ev_b && pend_b == 12'h000)
                pend_b <= second_sequence_config[`ADST_SEQ_CH_MSB:0];
            if (start_b && pend_b == 12'h000)
                pend_b <= pwdata[`ADST_SEQ_CH_MSB:0];
            if (ev_b || start_b) wait_b <= 1'b0;
            if ((ev_a || start_a) && go_a)
                overrun <= 1'b1;
            case (state)
                ST_IDLE: begin
                    conv_power <= ~control[`ADST_CTRL_LPWR_BIT];
                    if (go_a || go_b) begin
                        cur_b <= ~go_a;
                        clk_count <= 6'd0;
                        conv_power <= 1'b1;
                        state <= control[`ADST_CTRL_LPWR_BIT] ?
                            ST_WAKE : ST_CONV;
                        conv_len <= `ADST_CONV_CLKS + {3'h0,
                            go_a ?
                            first_sequence_config[`ADST_SEQ_EXTRA_SAMPLE_CLOCKS_MSB:
                            `ADST_SEQ_EXTRA_SAMPLE_CLOCKS_LSB] :
                            second_sequence_config[`ADST_SEQ_EXTRA_SAMPLE_CLOCKS_MSB:
                            `ADST_SEQ_EXTRA_SAMPLE_CLOCKS_LSB]};
                        conv_channel <= index_of(lowest(go_a
                            ? pend_a : pend_b));
                    end
                end
                ST_WAKE: begin
                    if (conv_tick) begin
                        clk_count <= clk_count + 6'd1;
                        if (clk_count == `ADST_WAKE_CLKS) begin
                            clk_count <= 6'd0;
                            state <= ST_CONV;
                        end
                    end
                end
                ST_CONV: begin
                    if (conv_tick) begin
                        if (clk_count == 6'd0)
                            conv_sample <= 1'b1;
                        clk_count <= clk_count + 6'd1;
                        if (clk_count == conv_len - 6'd1) begin
                            clk_count <= 6'd0;
                            channel_result_reg[conv_channel] <=
                                conv_code;
                            done_mask[conv_channel] <= 1'b1;
                            state <= ST_IDLE;
                            if (!cur_b) begin
                                gdat_a <= {conv_channel, conv_code};
                                pend_a <= pend_a & ~lowest(pend_a);
                                wait_a <= first_sequence_config[
                                    `ADST_SEQ_STEP_BIT];
                                if (!first_sequence_config[
                                    `ADST_SEQ_MODE_BIT] ||
                                    (pend_a & ~lowest(pend_a)) == 12'h000)
                                    first_sequence_interrupt <= 1'b1;
                            end else begin
                                gdat_b <= {conv_channel, conv_code};
                                pend_b <= pend_b & ~lowest(pend_b);
                                wait_b <= second_sequence_config[
                                    `ADST_SEQ_STEP_BIT];
                                if (!second_sequence_config[
                                    `ADST_SEQ_MODE_BIT] ||
                                    (pend_b & ~lowest(pend_b)) == 12'h000)
                                    second_sequence_interrupt <= 1'b1;
                            end
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // apb read and answer, zero wait states
    always @(posedge clock) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                if (paddr == `ADST_CTRL_OFF)
                    prdata <= control;
                else if (paddr == `ADST_SEQA_OFF)
                    prdata <= first_sequence_config;
                else if (paddr == `ADST_SEQB_OFF)
                    prdata <= second_sequence_config;
                else if (paddr == `ADST_GDATA_OFF)
                    prdata <= {16'h0000, gdat_a};
                else if (paddr == `ADST_GDATB_OFF)
                    prdata <= {16'h0000, gdat_b};
                else if (paddr == `ADST_STAT_OFF)
                    prdata <= {15'h0000, overrun, 4'h0, done_mask};
                else if (paddr >= `ADST_CHANNEL_RESULT_REG_OFF && paddr < 12'h050 &&
                    paddr[1:0] == 2'b00)
                    prdata <= {20'h00000,
                        channel_result_reg[paddr[5:2] - 4'h8]};
                else
                    pslverr <= 1'b1;
            end
        end
    end
endmodule

// file: inc/adst_consts.vh
`ifndef ADST_CONSTS_VH
`define ADST_CONSTS_VH

// register byte offsets
`define ADST_CTRL_OFF 12'h000
`define ADST_SEQA_OFF 12'h008
`define ADST_SEQB_OFF 12'h00c
`define ADST_GDATA_OFF 12'h010
`define ADST_GDATB_OFF 12'h014
`define ADST_STAT_OFF 12'h018
`define ADST_CHANNEL_RESULT_REG_OFF 12'h020

// control register fields
`define ADST_CTRL_DIV_LSB 0
`define ADST_CTRL_DIV_MSB 7
`define ADST_CTRL_ASYNC_BIT 8
`define ADST_CTRL_LPWR_BIT 10

// sequence config fields
`define ADST_SEQ_CH_MSB 11
`define ADST_SEQ_TRIG_LSB 12
`define ADST_SEQ_TRIG_MSB 15
`define ADST_SEQ_EXTRA_SAMPLE_CLOCKS_LSB 16
`define ADST_SEQ_EXTRA_SAMPLE_CLOCKS_MSB 18
`define ADST_SEQ_POL_BIT 19
`define ADST_SEQ_STEP_BIT 20
`define ADST_SEQ_START_BIT 26
`define ADST_SEQ_MODE_BIT 30
`define ADST_SEQUENCE_ENABLE_BIT_BIT 31

// trigger select codes
`define ADST_TRIG_NONE 4'h0
`define ADST_TRIG_PIN0 4'h1
`define ADST_TRIG_PIN1 4'h2
`define ADST_TRIG_TMR3 4'h5
`define ADST_TRIG_CMP 4'h6
`define ADST_TRIG_PMATCH 4'h7
`define ADST_TRIG_TXEV 4'h8

// reset values
`define ADST_CTRL_RST 32'h0000_0000
`define ADST_SEQ_RST 32'h0000_0000

// conversion timing in converter clocks, and the full-scale result code
`define ADST_CONV_CLKS 6'd31
`define ADST_WAKE_CLKS 6'd2
`define ADST_RESULT_MAX 12'hfff

`endif

// file: logic/adst_clock_divider.v
`include "adst_consts.vh"

module adst_clock_divider (
    // clock and reset
    input wire clock,
    input wire reset,
    // control
    input wire [7:0] divide,
    input wire async_mode,
    input wire async_tick,
    // output enable pulse
    output reg conv_tick
);
    reg [7:0] count;

    always @(posedge clock) begin
        if (reset) begin
            count <= 8'h00;
            conv_tick <= 1'b0;
        end else if (async_mode) begin
            count <= 8'h00;
            conv_tick <= async_tick;
        end else if (count >= divide) begin
            count <= 8'h00;
            conv_tick <= 1'b1;
        end else begin
            count <= count + 8'h01;
            conv_tick <= 1'b0;
        end
    end
endmodule

// file: verif/adst_core_model.sv
module adst_core_model (
    // converter core side
    input logic clock,
    input logic [3:0] conv_channel,
    input logic conv_sample,
    output logic [11:0] conv_code
);
    timeunit 1ns;
    timeprecision 1ps;
    // per-channel input codes, loaded by the bench
    logic [11:0] codes [12];
    logic [11:0] held = 12'h000;
    // input taken at the start of each conversion
    always @(posedge clock) begin
        if (conv_sample && conv_channel < 4'hc) begin
            held <= codes[conv_channel];
        end
    end
    assign conv_code = held;
endmodule

// file: verif/adst_sequencer_chk.sv
module adst_sequencer_chk (
    input logic clock,
    input logic reset,
    input logic psel,
    input logic penable,
    input logic pready,
    input logic pslverr,
    input logic [31:0] prdata,
    input logic [3:0] conv_channel,
    input logic conv_sample,
    input logic conv_power,
    input logic first_sequence_interrupt,
    input logic threshold_interrupt
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_ready_access: assert property (s_setup ##1 s_access |-> pready)
        else $error("no ready in access cycle");
    a_ready_cause: assert property (pready |-> s_access)
        else $error("ready outside access");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_data_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_sample_power: assert property (conv_sample |-> conv_power)
        else $error("sampling while powered down");
    a_channel_hold: assert property (
        conv_sample |=> $stable(conv_channel)[*8])
        else $error("channel moved during sampling");
    a_irq_gap: assert property (
        conv_sample |-> ##2 !first_sequence_interrupt[*8])
        else $error("interrupt too soon after sample");
    a_irq_pulse: assert property (
        first_sequence_interrupt |=> !first_sequence_interrupt)
        else $error("interrupt longer than one cycle");
    a_no_threshold: assert property (!threshold_interrupt)
        else $error("threshold interrupt raised");
endmodule

// file: verif/adst_sequencer_tb.sv
`include "adst_consts.vh"
module adst_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] EN = 32'h1 << `ADST_SEQUENCE_ENABLE_BIT_BIT;
    localparam logic [31:0] MD = 32'h1 << `ADST_SEQ_MODE_BIT;
    localparam logic [31:0] GO = 32'h1 << `ADST_SEQ_START_BIT;
    localparam logic [31:0] ST = 32'h1 << `ADST_SEQ_STEP_BIT;
    localparam logic [31:0] PL = 32'h1 << `ADST_SEQ_POL_BIT;
    logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [5:0] src = 6'h00;
    logic atick = 0;
    logic err;
    wire [31:0] prdata;
    wire [11:0] conv_code;
    wire [3:0] conv_channel;
    wire pready, pslverr, conv_sample, conv_power, irq_a, irq_b, irq_t, irq_o;
    int mismatches = 0, n_tests = 0, irqs = 0, seed = 32'h93bc4779;
    int t0, t7, base, n;
    logic [3:0] codes [6] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8};
    always #10 clock = ~clock;
    always @(posedge clock) atick <= ~atick;
    always @(posedge clock) if (irq_a === 1'b1) irqs <= irqs + 1;
    adst_sequencer dut_u (.clock(clock), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_event_zero(src[0]), .pin_event_one(src[1]),
        .timer_match_three(src[2]), .comparator_output_trigger(src[3]),
        .pattern_match_event(src[4]), .core_transmit_event(src[5]),
        .async_conv_tick(atick), .conv_channel(conv_channel),
        .conv_sample(conv_sample), .conv_power(conv_power),
        .conv_code(conv_code), .first_sequence_interrupt(irq_a),
        .second_sequence_interrupt(irq_b), .threshold_interrupt(irq_t),
        .overrun_interrupt(irq_o));
    adst_core_model mdl_u (.clock(clock), .conv_channel(conv_channel),
        .conv_sample(conv_sample), .conv_code(conv_code));
    task automatic chk(input logic [31:0] got, exp, input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) chk(0, 1, "apb timeout");
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clock);
    endtask
    task automatic wait_irqs(input int want);
        int k;
        k = 0;
        while (irqs < want && k < 3000) begin
            @(posedge clock);
            k++;
        end
        @(posedge clock);
    endtask
    task automatic measure(input int i, input logic b, output int t);
        int k;
        k = 0; t = 0;
        src[i] <= 1;
        while (conv_sample !== 1'b1 && k < 400) begin
            @(posedge clock);
            k++;
        end
        src[i] <= 0;
        while ((b ? irq_b : irq_a) !== 1'b1 && t < 400) begin
            @(posedge clock);
            t++;
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #400_000;
        mismatches++;
        summarize();
    end
    initial begin
        for (int i = 0; i < 12; i++) mdl_u.codes[i] = 12'($random(seed));
        mdl_u.codes[0] = 12'h000;
        mdl_u.codes[11] = `ADST_RESULT_MAX;
        repeat (6) @(posedge clock);
        reset <= 0;
        @(posedge clock);
        apb(0, `ADST_SEQA_OFF, 0); chk(rd, `ADST_SEQ_RST, "seqa reset");
        apb(0, 12'h004, 0); chk(err, 1, "unmapped error");
        apb(1, `ADST_SEQA_OFF, 32'h1000); apb(1, `ADST_SEQB_OFF, 32'h5000);
        apb(0, `ADST_SEQA_OFF, 0); chk(rd, 32'h1000, "seqa select");
        apb(0, `ADST_SEQB_OFF, 0); chk(rd, 32'h5000, "seqb select");
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            n = {$random(seed)} % 12;
            base = irqs;
            apb(1, `ADST_SEQA_OFF, EN | PL | (codes[i] << 12) | (1 << n));
            src[i] <= 1;
            wait_irqs(base + 1);
            src[i] <= 0;
            chk(irqs, base + 1, "hw trigger");
            apb(0, `ADST_CHANNEL_RESULT_REG_OFF + 4 * n, 0);
            chk(rd[11:0], mdl_u.codes[n], "result");
            apb(1, `ADST_SEQA_OFF, 0);
        end
        $display("test trigger codes done");
        base = irqs;
        for (int c = 3; c < 5; c++) begin
            apb(1, `ADST_SEQA_OFF,
                EN | (c == 3 ? PL : 32'h0) | (c << 12) | 32'h1);
            src <= 6'h3f;
            repeat (40) @(posedge clock);
            src <= 6'h00;
            repeat (150) @(posedge clock);
        end
        chk(irqs, base, "unassigned code");
        $display("test unassigned codes done");
        apb(1, `ADST_SEQA_OFF, 0);
        for (int r = 1; r < 3; r++) begin
            apb(1, `ADST_SEQA_OFF, EN | PL | GO | 32'h2);
            wait_irqs(base + r);
            chk(irqs, base + r, "software start");
        end
        apb(0, `ADST_CHANNEL_RESULT_REG_OFF + 4, 0);
        chk(rd[11:0], mdl_u.codes[1], "channel one");
        apb(0, `ADST_GDATA_OFF, 0);
        chk(rd, 32'h1000 | mdl_u.codes[1], "global data");
        $display("test software start done");
        base = irqs;
        apb(1, `ADST_SEQA_OFF, EN | MD | PL | GO | 32'hf);
        repeat (600) @(posedge clock);
        chk(irqs, base + 1, "one sequence irq");
        for (int c = 0; c < 4; c++) begin
            apb(0, `ADST_CHANNEL_RESULT_REG_OFF + 4 * c, 0);
            chk(rd[11:0], mdl_u.codes[c], "sequence result");
        end
        $display("test whole sequence done");
        base = irqs;
        for (int c = 0; c < 4; c++) begin
            apb(1, `ADST_SEQA_OFF, EN | MD | ST | PL | GO | 32'hf);
            n = 0;
            while (conv_sample !== 1'b1 && n < 400) begin
                @(posedge clock);
                n++;
            end
            chk(conv_channel, c, "step channel");
            repeat (100) @(posedge clock);
            chk(irqs, base + (c == 3), "step irq");
        end
        $display("test single step done");
        apb(1, `ADST_SEQA_OFF, EN | PL | 32'h1000 | 32'h1);
        apb(1, `ADST_SEQB_OFF, EN | PL | 32'h5000 | 32'h70002);
        measure(0, 0, t0);
        repeat (20) @(posedge clock);
        measure(2, 1, t7);
        chk(t0, 30, "conversion time");
        chk(t7 - t0, 7, "extra sample time");
        apb(1, `ADST_CTRL_OFF, 32'h1 << `ADST_CTRL_ASYNC_BIT);
        measure(0, 0, t0);
        chk(t0, 60, "async converter clock");
        $display("test sample time done");
        apb(1, `ADST_SEQB_OFF, 0);
        apb(1, `ADST_CTRL_OFF, 32'h1 << `ADST_CTRL_LPWR_BIT);
        repeat (20) @(posedge clock);
        chk(conv_power, 0, "idle power off");
        base = irqs;
        apb(1, `ADST_SEQA_OFF, EN | PL | GO | 32'h1);
        wait_irqs(base + 1);
        chk(irqs, base + 1, "wake conversion");
        $display("test low power done");
        base = irqs;
        apb(1, `ADST_SEQA_OFF, EN | PL | GO | 32'h3);
        apb(1, `ADST_SEQA_OFF, EN | PL | GO | 32'h3);
        @(posedge clock);
        chk(irq_o, 1, "overrun flag");
        apb(0, `ADST_STAT_OFF, 0);
        chk(rd[16], 1, "overrun status");
        @(posedge clock);
        chk(irq_o, 0, "overrun cleared");
        wait_irqs(base + 2);
        chk(irqs, base + 2, "start ignored");
        $display("test overrun done");
        summarize();
    end
endmodule
bind adst_sequencer adst_sequencer_chk chk_u (.clock(clock), .reset(reset),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .conv_channel(conv_channel),
    .conv_sample(conv_sample), .conv_power(conv_power),
    .first_sequence_interrupt(first_sequence_interrupt),
    .threshold_interrupt(threshold_interrupt));
